/* hw/dbc_consts.svh */
`ifndef DBC_CONSTS_SVH
`define DBC_CONSTS_SVH

// ----------------------------------------
// Word geometry
// ----------------------------------------
`define DBC_WORD_BITS     20
`define DBC_WFIELD_BITS   16
`define DBC_CFIELD_BITS   4
`define DBC_CTRL_BITS     14
`define DBC_CTRL_LO_BITS  7
`define DBC_WORD_LAST     5'h13
`define DBC_HALF_ONES     5'h0A

// ----------------------------------------
// Coding fields, c0 is the leftmost digit
// ----------------------------------------
`define DBC_C_DATA_F0     4'hD
`define DBC_C_DATA_F1     4'hB
`define DBC_C_CTRL_F0     4'h3
`define DBC_C_CTRL_F1     4'h5
`define DBC_W78_CTRL      2'h1

// ----------------------------------------
// Idle word fields, w0 is the leftmost digit
// ----------------------------------------
`define DBC_IDLE_A        16'hFF80
`define DBC_IDLE_B        16'hFE00

// ----------------------------------------
// Range dividers, scrambler, accumulator and queue
// ----------------------------------------
`define DBC_DIV1_LAST     2'h0
`define DBC_DIV2_LAST     2'h1
`define DBC_DIV4_LAST     2'h3
`define DBC_TEST_CLK_SEL  2'h3
`define DBC_SCR_LEN       7
`define DBC_SCR_TAP_A     6
`define DBC_SCR_TAP_B     4
`define DBC_DISP_BITS     8
`define DBC_FIFO_DEPTH    8

`endif

/* hw/dbc_pkg.sv */
`include "dbc_consts.svh"

package dbc_pkg;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		KIND_IDLE = 2'b00,
		KIND_DATA = 2'b01,
		KIND_CTRL = 2'b10,
		KIND_ERR  = 2'b11
	} dbc_kind_e;

	typedef enum logic {
		RXS_WAIT_LOCK = 1'b0,
		RXS_TRACK     = 1'b1
	} dbc_rx_state_e;

	typedef logic [0:`DBC_WORD_BITS-1] dbc_line_t;
	typedef logic [`DBC_SCR_LEN-1:0]   dbc_scr_t;

	typedef struct packed {
		logic        dv;
		logic        cv;
		logic        flag;
		logic [15:0] data;
	} dbc_tx_entry_s;

	typedef struct packed {
		dbc_kind_e   kind;
		logic        line_flag;
		logic [15:0] data;
	} dbc_rx_word_s;

	// ----------------------------------------
	// Shared functions
	// ----------------------------------------
	function automatic logic scr_mask(input dbc_scr_t hist);
		return hist[`DBC_SCR_TAP_A] ^ hist[`DBC_SCR_TAP_B];
	endfunction : scr_mask

	function automatic logic [1:0] range_last(input logic [1:0] sel);
		if (sel[1])
			return `DBC_DIV4_LAST;
		else if (sel[0])
			return `DBC_DIV2_LAST;
		else
			return `DBC_DIV1_LAST;
	endfunction : range_last

endpackage : dbc_pkg

/* hw/dbc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module dbc_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_arst_n,
	// Fill side
	input  wire logic             i_in_valid,
	output var  logic             o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output var  logic             o_out_valid,
	input  wire logic             i_out_ready,
	output var  logic [WIDTH-1:0] o_out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;
	logic [CW-1:0]    count_next;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : ptr_inc

	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;
	assign o_out_valid = (count_reg != '0);
	assign o_out_data  = mem[rd_ptr_reg];
	assign count_next  = CW'(count_reg + CW'(push) - CW'(pop));

	always_ff @(posedge i_clk) begin
		if (push)
			mem[wr_ptr_reg] <= i_in_data;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			o_in_ready <= 1'b0;
		end else begin
			if (push)
				wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			if (pop)
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			count_reg  <= count_next;
			// Registered ready, so it reflects the count after this edge
			o_in_ready <= (count_next < CW'(DEPTH));
		end
	end

endmodule : dbc_fifo

`default_nettype wire

/* hw/dbc_rx_decode.sv */
`timescale 1ns/1ps
`default_nettype none

module dbc_rx_decode
	import dbc_pkg::*;
(
	// Received word, w0 already restored
	input  wire logic           i_esm,
	input  wire dbc_pkg::dbc_line_t i_word,
	// Decoded result
	output var  dbc_pkg::dbc_rx_word_s o_dec
);
	logic [0:15] wf;
	logic [0:3]  cf;
	logic [1:0]  w78;
	logic        inv;

	assign wf  = i_word[0:15];
	assign cf  = i_word[16:19];
	assign w78 = {wf[7], wf[8]};

	always_comb begin
		logic [0:15] tw;
		tw = '0;
		inv = 1'b0;
		o_dec.kind = KIND_ERR;
		o_dec.line_flag = 1'b0;
		o_dec.data = '0;
		// Coding field plus w7 w8 classify the word
		unique case (cf)
			`DBC_C_DATA_F0, ~`DBC_C_DATA_F0: begin
				o_dec.kind = KIND_DATA;
				inv = (cf == ~`DBC_C_DATA_F0);
			end
			`DBC_C_DATA_F1, ~`DBC_C_DATA_F1: begin
				o_dec.kind = KIND_DATA;
				o_dec.line_flag = 1'b1;
				inv = (cf == ~`DBC_C_DATA_F1);
			end
			`DBC_C_CTRL_F0: begin
				if (w78 == `DBC_W78_CTRL)
					o_dec.kind = KIND_CTRL;
				else if (w78[0] == w78[1])
					o_dec.kind = KIND_IDLE;
			end
			~`DBC_C_CTRL_F0: begin
				inv = 1'b1;
				if (w78 == ~`DBC_W78_CTRL)
					o_dec.kind = KIND_CTRL;
			end
			`DBC_C_CTRL_F1: begin
				o_dec.line_flag = 1'b1;
				if (i_esm && w78 == `DBC_W78_CTRL)
					o_dec.kind = KIND_CTRL;
				else if (i_esm && w78[0] == w78[1])
					o_dec.kind = KIND_IDLE;
			end
			~`DBC_C_CTRL_F1: begin
				o_dec.line_flag = 1'b1;
				inv = 1'b1;
				if (i_esm && w78 == ~`DBC_W78_CTRL)
					o_dec.kind = KIND_CTRL;
			end
			default: o_dec.kind = KIND_ERR;
		endcase
		tw = inv ? ~wf : wf;
		if (o_dec.kind == KIND_DATA) begin
			for (int i = 0; i < 16; i++)
				o_dec.data[i] = tw[i];
		end else if (o_dec.kind == KIND_CTRL) begin
			// Drop w7 w8 so control bits are contiguous
			for (int i = 0; i < `DBC_CTRL_LO_BITS; i++)
				o_dec.data[i] = tw[i];
			for (int i = `DBC_CTRL_LO_BITS; i < `DBC_CTRL_BITS; i++)
				o_dec.data[i] = tw[i+2];
		end
	end

endmodule : dbc_rx_decode

`default_nettype wire

/* hw/dbc_codec_top.sv */
// Summary of operation
// - Word is 16 w bits then 4 c bits
// - Data word: bits in w, flag picks c
// - Control: 14 bits, w7w8 01, flag c
// - Queue inputs, take one per word tick
// - Valids select data, control or idle
// - Invert when word sign equals history
// - Idle words are never inverted
// - Extra bit enabled: flag is 17th bit
// - Extra bit disabled: flag alternates per data
// - Idle A if sign low, B if high
// - Enhanced mode scrambles flag end to end
// - Enhanced mode scrambles and restores w0
// - Bad c1c2 or control middle is error
// - Serial rate divided by 1, 2, 4
// - External serial clock replaces oscillator
// - Word rate derived from serial clock
// - Receiver test clock when both selects high
// - Track bits only after lock indicated
// - Classify by c field and w7 w8
// - Undo inversion before presenting word
// - Control bits realigned onto outputs 0..13
// - Data, control indicators; idle all low
// - Empty queue means send idle
// - w0 first through c3 last
// - Plain mode: control and idle flagless
// - Resync word boundary on code errors
`timescale 1ns/1ps
`default_nettype none

module dbc_codec_top
	import dbc_pkg::*;
#(
	parameter int FIFO_DEPTH = `DBC_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_ARST_N,
	// Transmit user port
	input  wire logic [15:0] I_TX_DATA,
	input  wire logic        I_TX_DATA_WORD_VALID,
	input  wire logic        I_TX_CONTROL_WORD_VALID,
	input  wire logic        I_TX_EXTRA_BIT_IN,
	output var  logic        O_TX_READY,
	// Transmit configuration
	input  wire logic        I_TX_EXTRA_BIT_ENABLE,
	input  wire logic        I_ENHANCED_SIMPLEX_ENABLE,
	input  wire logic        I_EXTERNAL_SERIAL_CLOCK_SELECT,
	input  wire logic        I_TX_WORD_CLOCK_IN,
	input  wire logic        I_TX_RANGE_SELECT_HI,
	input  wire logic        I_TX_RANGE_SELECT_LO,
	// Serial line
	output var  logic        O_SERIAL_LINE_OUT,
	input  wire logic        I_SERIAL_LINE_IN,
	// Receive configuration
	input  wire logic        I_RX_RANGE_SELECT_HI,
	input  wire logic        I_RX_RANGE_SELECT_LO,
	input  wire logic        I_RX_TEST_CLOCK_IN,
	input  wire logic        I_RX_FREQ_LOCKED,
	input  wire logic        I_WORD_RESYNC_DISABLE,
	// Receive user port
	output var  logic [15:0] O_RX_WORD,
	output var  logic        O_RX_FLAG,
	output var  logic        O_RX_DATA_WORD_SEEN,
	output var  logic        O_RX_CONTROL_WORD_SEEN,
	output var  logic        O_RX_CODE_ERROR,
	output var  logic        O_RX_WORD_STROBE,
	output var  logic        O_RX_TRACKING
);
	import dbc_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [1:0]      tx_sel;
	logic [1:0]      rx_sel;
	logic            tx_clk_prev_reg;
	logic            rx_clk_prev_reg;
	logic            tx_src;
	logic            rx_src;
	logic            rx_test_mode;
	logic [1:0]      tx_div_reg;
	logic [1:0]      rx_div_reg;
	logic [1:0]      rx_last;
	logic            tx_bit_tick_reg;
	logic            rx_bit_tick_reg;
	logic [4:0]      tx_bit_cnt_reg;
	logic            tx_word_tick;
	dbc_line_t       tx_sh_reg;
	dbc_tx_entry_s   fifo_in;
	dbc_tx_entry_s   head;
	logic            head_valid;
	dbc_kind_e       tx_kind;
	logic            oe_toggle_reg;
	logic            flag_raw;
	logic            flag_line;
	logic [0:15]     wf_true;
	logic [0:3]      cf_true;
	dbc_line_t       word_true;
	dbc_line_t       word_line;
	logic [4:0]      ones;
	logic            word_sign;
	logic            do_invert;
	logic signed [`DBC_DISP_BITS-1:0] acc_reg;
	logic signed [`DBC_DISP_BITS-1:0] acc_next;
	logic            accumulated_sign;
	dbc_scr_t        tx_flag_hist_reg;
	dbc_scr_t        tx_w0_hist_reg;
	dbc_rx_state_e   rx_state_reg;
	dbc_line_t       rx_sh_reg;
	dbc_line_t       rx_sh_next;
	dbc_line_t       rx_restored;
	logic [4:0]      rx_bit_cnt_reg;
	logic            rx_word_done;
	dbc_rx_word_s    rx_dec;
	logic            rx_err;
	dbc_scr_t        rx_flag_hist_reg;
	dbc_scr_t        rx_w0_hist_reg;

	// ----------------------------------------
	// Transmit clocking
	// ----------------------------------------
	assign tx_sel       = {I_TX_RANGE_SELECT_HI, I_TX_RANGE_SELECT_LO};
	// External serial clock is for diagnostics; its rising edges
	// stand in for the oscillator
	assign tx_src       = I_EXTERNAL_SERIAL_CLOCK_SELECT ?
		(I_TX_WORD_CLOCK_IN & ~tx_clk_prev_reg) : 1'b1;
	assign tx_word_tick = tx_bit_tick_reg && (tx_bit_cnt_reg == `DBC_WORD_LAST);

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			tx_clk_prev_reg <= 1'b0;
			tx_div_reg      <= '0;
			tx_bit_tick_reg <= 1'b0;
		end else begin
			tx_clk_prev_reg <= I_TX_WORD_CLOCK_IN;
			tx_bit_tick_reg <= 1'b0;
			if (tx_src) begin
				if (tx_div_reg >= range_last(tx_sel)) begin
					tx_div_reg      <= '0;
					tx_bit_tick_reg <= 1'b1;
				end else begin
					tx_div_reg <= tx_div_reg + 2'h1;
				end
			end
		end
	end

	// ----------------------------------------
	// Transmit queue
	// ----------------------------------------
	assign fifo_in = '{dv: I_TX_DATA_WORD_VALID, cv: I_TX_CONTROL_WORD_VALID,
		flag: I_TX_EXTRA_BIT_IN, data: I_TX_DATA};

	// Only real words are queued; an empty queue yields idle words
	dbc_fifo #(
		.WIDTH ($bits(dbc_tx_entry_s)),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.i_clk       (I_CLK),
		.i_arst_n    (I_ARST_N),
		.i_in_valid  (I_TX_DATA_WORD_VALID | I_TX_CONTROL_WORD_VALID),
		.o_in_ready  (O_TX_READY),
		.i_in_data   (fifo_in),
		.o_out_valid (head_valid),
		.i_out_ready (tx_word_tick),
		.o_out_data  (head)
	);

	// ----------------------------------------
	// Transmit encoder
	// ----------------------------------------
	assign accumulated_sign = acc_reg[`DBC_DISP_BITS-1];

	always_comb begin
		if (head_valid && head.dv)
			tx_kind = KIND_DATA;
		else if (head_valid && head.cv)
			tx_kind = KIND_CTRL;
		else
			tx_kind = KIND_IDLE;
	end

	always_comb begin
		flag_raw = 1'b0;
		if (tx_kind == KIND_DATA)
			flag_raw = I_TX_EXTRA_BIT_ENABLE ? head.flag : oe_toggle_reg;
		flag_line = flag_raw;
		if (I_ENHANCED_SIMPLEX_ENABLE)
			flag_line = flag_raw ^ scr_mask(tx_flag_hist_reg);
	end

	always_comb begin
		wf_true = '0;
		cf_true = `DBC_C_CTRL_F0;
		unique case (tx_kind)
			KIND_DATA: begin
				for (int i = 0; i < 16; i++)
					wf_true[i] = head.data[i];
				cf_true = flag_line ? `DBC_C_DATA_F1 : `DBC_C_DATA_F0;
			end
			KIND_CTRL: begin
				for (int i = 0; i < `DBC_CTRL_LO_BITS; i++)
					wf_true[i] = head.data[i];
				{wf_true[7], wf_true[8]} = `DBC_W78_CTRL;
				for (int i = `DBC_CTRL_LO_BITS; i < `DBC_CTRL_BITS; i++)
					wf_true[i+2] = head.data[i];
				if (I_ENHANCED_SIMPLEX_ENABLE && flag_line)
					cf_true = `DBC_C_CTRL_F1;
			end
			KIND_IDLE: begin
				wf_true = accumulated_sign ? `DBC_IDLE_B : `DBC_IDLE_A;
				if (I_ENHANCED_SIMPLEX_ENABLE && flag_line)
					cf_true = `DBC_C_CTRL_F1;
			end
			default: wf_true = '0;
		endcase
	end

	assign word_true = {wf_true, cf_true};

	always_comb begin
		ones = '0;
		for (int i = 0; i < `DBC_WORD_BITS; i++)
			ones = 5'(ones + 5'(word_true[i]));
	end

	// The accumulator counts zeros up and ones down, so its sign bit is
	// high once ones lead; idle A then pulls a zero-heavy line back to
	// balance. A word's sign uses the same sense: high when ones lead
	assign word_sign = (ones > `DBC_HALF_ONES);
	assign do_invert = (tx_kind != KIND_IDLE) && (word_sign == accumulated_sign);

	always_comb begin
		word_line = do_invert ? ~word_true : word_true;
		if (I_ENHANCED_SIMPLEX_ENABLE)
			word_line[0] = word_line[0] ^ scr_mask(tx_w0_hist_reg);
	end

	always_comb begin
		acc_next = acc_reg;
		for (int i = 0; i < `DBC_WORD_BITS; i++)
			acc_next = word_line[i] ? `DBC_DISP_BITS'(acc_next - 1) :
				`DBC_DISP_BITS'(acc_next + 1);
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			acc_reg          <= '0;
			oe_toggle_reg    <= 1'b0;
			tx_flag_hist_reg <= '0;
			tx_w0_hist_reg   <= '0;
		end else if (tx_word_tick) begin
			acc_reg          <= acc_next;
			if (tx_kind == KIND_DATA)
				oe_toggle_reg <= ~oe_toggle_reg;
			tx_flag_hist_reg <= {tx_flag_hist_reg[`DBC_SCR_LEN-2:0], flag_line};
			tx_w0_hist_reg   <= {tx_w0_hist_reg[`DBC_SCR_LEN-2:0], word_line[0]};
		end
	end

	// ----------------------------------------
	// Serializer
	// ----------------------------------------
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			tx_bit_cnt_reg    <= `DBC_WORD_LAST;
			tx_sh_reg         <= '0;
			O_SERIAL_LINE_OUT <= 1'b0;
		end else if (tx_bit_tick_reg) begin
			if (tx_word_tick) begin
				tx_bit_cnt_reg    <= '0;
				O_SERIAL_LINE_OUT <= word_line[0];
				tx_sh_reg         <= {word_line[1:19], 1'b0};
			end else begin
				tx_bit_cnt_reg    <= tx_bit_cnt_reg + 5'h01;
				O_SERIAL_LINE_OUT <= tx_sh_reg[0];
				tx_sh_reg         <= {tx_sh_reg[1:19], 1'b0};
			end
		end
	end

	// ----------------------------------------
	// Receive clocking
	// ----------------------------------------
	assign rx_sel       = {I_RX_RANGE_SELECT_HI, I_RX_RANGE_SELECT_LO};
	assign rx_test_mode = (rx_sel == `DBC_TEST_CLK_SEL);
	assign rx_src       = rx_test_mode ?
		(I_RX_TEST_CLOCK_IN & ~rx_clk_prev_reg) : 1'b1;
	assign rx_last      = rx_test_mode ? `DBC_DIV1_LAST : range_last(rx_sel);

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rx_clk_prev_reg <= 1'b0;
			rx_div_reg      <= '0;
			rx_bit_tick_reg <= 1'b0;
		end else begin
			rx_clk_prev_reg <= I_RX_TEST_CLOCK_IN;
			rx_bit_tick_reg <= 1'b0;
			if (rx_src) begin
				if (rx_div_reg >= rx_last) begin
					rx_div_reg      <= '0;
					rx_bit_tick_reg <= 1'b1;
				end else begin
					rx_div_reg <= rx_div_reg + 2'h1;
				end
			end
		end
	end

	// ----------------------------------------
	// Receive lock and word alignment
	// ----------------------------------------
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rx_state_reg <= RXS_WAIT_LOCK;
		end else begin
			unique case (rx_state_reg)
				RXS_WAIT_LOCK: if (I_RX_FREQ_LOCKED) rx_state_reg <= RXS_TRACK;
				RXS_TRACK:     if (!I_RX_FREQ_LOCKED) rx_state_reg <= RXS_WAIT_LOCK;
			endcase
		end
	end

	assign rx_sh_next   = {rx_sh_reg[1:19], I_SERIAL_LINE_IN};
	assign rx_word_done = rx_bit_tick_reg && (rx_state_reg == RXS_TRACK) &&
		(rx_bit_cnt_reg == `DBC_WORD_LAST);

	always_comb begin
		rx_restored = rx_sh_next;
		if (I_ENHANCED_SIMPLEX_ENABLE)
			rx_restored[0] = rx_sh_next[0] ^ scr_mask(rx_w0_hist_reg);
	end

	dbc_rx_decode u_rx_decode (
		.i_esm  (I_ENHANCED_SIMPLEX_ENABLE),
		.i_word (rx_restored),
		.o_dec  (rx_dec)
	);

	assign rx_err = (rx_dec.kind == KIND_ERR);

	// On an error the window slides one bit and is checked again,
	// which hunts for the boundary bit by bit
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rx_sh_reg      <= '0;
			rx_bit_cnt_reg <= '0;
		end else if (rx_state_reg != RXS_TRACK) begin
			rx_bit_cnt_reg <= '0;
		end else if (rx_bit_tick_reg) begin
			rx_sh_reg <= rx_sh_next;
			if (rx_word_done && rx_err && !I_WORD_RESYNC_DISABLE)
				rx_bit_cnt_reg <= `DBC_WORD_LAST;
			else if (rx_word_done)
				rx_bit_cnt_reg <= '0;
			else
				rx_bit_cnt_reg <= rx_bit_cnt_reg + 5'h01;
		end
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rx_flag_hist_reg <= '0;
			rx_w0_hist_reg   <= '0;
		end else if (rx_word_done && !rx_err) begin
			rx_flag_hist_reg <= {rx_flag_hist_reg[`DBC_SCR_LEN-2:0], rx_dec.line_flag};
			rx_w0_hist_reg   <= {rx_w0_hist_reg[`DBC_SCR_LEN-2:0], rx_sh_next[0]};
		end
	end

	// ----------------------------------------
	// Receive user outputs
	// ----------------------------------------
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_RX_WORD              <= '0;
			O_RX_FLAG              <= 1'b0;
			O_RX_DATA_WORD_SEEN    <= 1'b0;
			O_RX_CONTROL_WORD_SEEN <= 1'b0;
			O_RX_CODE_ERROR        <= 1'b0;
			O_RX_WORD_STROBE       <= 1'b0;
			O_RX_TRACKING          <= 1'b0;
		end else begin
			O_RX_TRACKING    <= (rx_state_reg == RXS_TRACK);
			O_RX_WORD_STROBE <= rx_word_done;
			if (rx_word_done) begin
				O_RX_WORD              <= rx_dec.data;
				O_RX_DATA_WORD_SEEN    <= (rx_dec.kind == KIND_DATA);
				O_RX_CONTROL_WORD_SEEN <= (rx_dec.kind == KIND_CTRL);
				O_RX_CODE_ERROR        <= rx_err;
				// Flag reaches the user only with data words
				if (rx_dec.kind == KIND_DATA)
					O_RX_FLAG <= I_ENHANCED_SIMPLEX_ENABLE ?
						(rx_dec.line_flag ^ scr_mask(rx_flag_hist_reg)) :
						rx_dec.line_flag;
				else
					O_RX_FLAG <= 1'b0;
			end
		end
	end

endmodule : dbc_codec_top

`default_nettype wire

/* tb/dbc_peer_model.sv */
`timescale 1ns/1ps
`default_nettype none

module dbc_peer_model (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	// Line from the codec, slip control
	input  wire logic i_line_in,
	input  wire logic i_slip,
	// Line back to the codec
	output var  logic o_line_out
);
	logic dly_reg;

	// ------
	// Echo path
	// ------
	// Slip adds one clock of delay, so at divide by 1 the word boundary moves by one bit
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			dly_reg    <= 1'b0;
			o_line_out <= 1'b0;
		end else begin
			dly_reg    <= i_line_in;
			o_line_out <= i_slip ? dly_reg : i_line_in;
		end
	end
endmodule : dbc_peer_model

`default_nettype wire

/* tb/dbc_codec_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module dbc_codec_chk (
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_ARST_N,
	// Inputs watched
	input  wire logic        I_TX_DATA_WORD_VALID,
	input  wire logic        I_TX_CONTROL_WORD_VALID,
	input  wire logic        I_RX_FREQ_LOCKED,
	// Outputs watched
	input  wire logic        O_TX_READY,
	input  wire logic [15:0] O_RX_WORD,
	input  wire logic        O_RX_FLAG,
	input  wire logic        O_RX_DATA_WORD_SEEN,
	input  wire logic        O_RX_CONTROL_WORD_SEEN,
	input  wire logic        O_RX_CODE_ERROR,
	input  wire logic        O_RX_WORD_STROBE,
	input  wire logic        O_RX_TRACKING
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_ARST_N);

	// ------
	// Properties
	// ------
	sequence s_good_word;
		O_RX_WORD_STROBE && !O_RX_CODE_ERROR;
	endsequence
	sequence s_quiet;
		!O_RX_WORD_STROBE [*8];
	endsequence
	property p_strobe_gap;
		s_good_word |=> s_quiet;
	endproperty
	property p_data_excl;
		O_RX_DATA_WORD_SEEN |-> !O_RX_CONTROL_WORD_SEEN && !O_RX_CODE_ERROR;
	endproperty
	property p_ctrl_excl;
		O_RX_CONTROL_WORD_SEEN |-> !O_RX_CODE_ERROR;
	endproperty
	property p_flag_data;
		O_RX_FLAG |-> O_RX_DATA_WORD_SEEN;
	endproperty
	property p_ctrl_top;
		O_RX_CONTROL_WORD_SEEN |-> O_RX_WORD[15:14] == 2'h0;
	endproperty
	property p_track;
		$rose(O_RX_TRACKING) |-> $past(I_RX_FREQ_LOCKED, 2);
	endproperty
	property p_hold;
		!O_RX_WORD_STROBE |-> $stable(O_RX_WORD) && $stable(O_RX_DATA_WORD_SEEN);
	endproperty
	property p_ready_fall;
		$fell(O_TX_READY) |-> $past(I_TX_DATA_WORD_VALID || I_TX_CONTROL_WORD_VALID)
			|| $past(I_TX_DATA_WORD_VALID || I_TX_CONTROL_WORD_VALID, 2);
	endproperty

	a_strobe_gap: assert property (p_strobe_gap) else $error("word strobes too close");
	a_data_excl: assert property (p_data_excl) else $error("data kind not exclusive");
	a_ctrl_excl: assert property (p_ctrl_excl) else $error("control kind with error");
	a_flag_data: assert property (p_flag_data) else $error("flag on non-data word");
	a_ctrl_top: assert property (p_ctrl_top) else $error("control bits not packed");
	a_track: assert property (p_track) else $error("tracking without lock");
	a_hold: assert property (p_hold) else $error("word changed without strobe");
	a_ready_fall: assert property (p_ready_fall) else $error("ready fell without push");
endmodule : dbc_codec_chk

bind dbc_codec_top dbc_codec_chk dbc_codec_chk_inst (.I_CLK, .I_ARST_N,
	.I_TX_DATA_WORD_VALID, .I_TX_CONTROL_WORD_VALID, .I_RX_FREQ_LOCKED, .O_TX_READY,
	.O_RX_WORD, .O_RX_FLAG, .O_RX_DATA_WORD_SEEN, .O_RX_CONTROL_WORD_SEEN,
	.O_RX_CODE_ERROR, .O_RX_WORD_STROBE, .O_RX_TRACKING);

`default_nettype wire

/* tb/tb_dbc_codec_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_dbc_codec_top;
	import dbc_pkg::*;

	logic        clk, rst_n, dv, cv, fl, fen, lock, rsd, slip, esm;
	logic        rdy, lo, li, rfl, rd, rc, re, rs, rt;
	logic [1:0]  rng;
	logic [15:0] din, rw;
	logic [16:0] q[$];
	int          n_mismatch, n_tests;

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	dbc_codec_top dbc_codec_top_inst (.I_CLK(clk), .I_ARST_N(rst_n), .I_TX_DATA(din),
		.I_TX_DATA_WORD_VALID(dv), .I_TX_CONTROL_WORD_VALID(cv), .I_TX_EXTRA_BIT_IN(fl),
		.O_TX_READY(rdy), .I_TX_EXTRA_BIT_ENABLE(fen), .I_ENHANCED_SIMPLEX_ENABLE(esm),
		.I_EXTERNAL_SERIAL_CLOCK_SELECT(1'b0), .I_TX_WORD_CLOCK_IN(1'b0),
		.I_TX_RANGE_SELECT_HI(rng[1]), .I_TX_RANGE_SELECT_LO(rng[0]),
		.O_SERIAL_LINE_OUT(lo), .I_SERIAL_LINE_IN(li), .I_RX_RANGE_SELECT_HI(rng[1]),
		.I_RX_RANGE_SELECT_LO(rng[0]), .I_RX_TEST_CLOCK_IN(1'b0), .I_RX_FREQ_LOCKED(lock),
		.I_WORD_RESYNC_DISABLE(rsd), .O_RX_WORD(rw), .O_RX_FLAG(rfl),
		.O_RX_DATA_WORD_SEEN(rd), .O_RX_CONTROL_WORD_SEEN(rc), .O_RX_CODE_ERROR(re),
		.O_RX_WORD_STROBE(rs), .O_RX_TRACKING(rt));

	dbc_peer_model dbc_peer_model_inst (.i_clk(clk), .i_arst_n(rst_n), .i_line_in(lo),
		.i_slip(slip), .o_line_out(li));

	// ------
	// Helpers
	// ------
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	task automatic check(input string nm, input logic [16:0] exp, input logic [16:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	task automatic give_up(input string nm);
		n_mismatch++;
		$display("wrong value %s expected event seen none", nm);
		wrap_up();
	endtask : give_up

	// Strobe stands one cycle, so look mid-cycle where it is settled
	task automatic next_word();
		for (int i = 0; i < 100; i++) begin
			@(negedge clk);
			if (rs === 1'b1)
				return;
		end
		give_up("word_strobe");
	endtask : next_word

	task automatic wait_kind(input logic [2:0] k);
		for (int i = 0; i < 80; i++) begin
			next_word();
			if ({rd, rc, re} === k)
				return;
		end
		give_up("word_kind");
	endtask : wait_kind

	task automatic push(input logic d, input logic c, input logic [15:0] v);
		int i;
		@(posedge clk);
		dv <= d;
		cv <= c;
		din <= v;
		for (i = 0; i < 100; i++) begin
			@(negedge clk);
			if (rdy === 1'b1)
				break;
		end
		if (i == 100)
			give_up("tx_ready");
		@(posedge clk);
		dv <= 1'b0;
		cv <= 1'b0;
	endtask : push

	// ------
	// Scenarios
	// ------
	task automatic t_idle();
		@(posedge clk);
		lock <= 1'b1;
		wait_kind(3'h0);
		check("tracking", 17'h1, {16'h0, rt});
		for (int j = 0; j < 3; j++) begin
			next_word();
			check("idle_kind", 17'h0, {14'h0, rd, rc, re});
		end
		$display("test idle done");
	endtask : t_idle

	// Pushes run ahead of the drain so the queue must refuse for a while
	task automatic t_data();
		int i, acc, full;
		acc = 0;
		full = 0;
		fork
			begin
				@(posedge clk);
				dv <= 1'b1;
				for (i = 0; acc < 10 && i < 400; i++) begin
					@(negedge clk);
					if (rdy === 1'b1) begin
						q.push_back({fl, din});
						acc++;
					end else
						full++;
					@(posedge clk);
					din <= din + 16'h1357;
					fl <= ~fl;
				end
				dv <= 1'b0;
			end
			for (int j = 0; j < 10; j++) begin
				wait_kind(3'h4);
				check("data_word", q.pop_front(), {rfl, rw});
			end
		join
		check("ready_refused", 17'h1, {16'h0, full > 0});
		$display("test data done");
	endtask : t_data

	task automatic t_ctrl();
		logic f1;
		@(posedge clk);
		fen <= 1'b0;
		push(1'b0, 1'b1, 16'hFABC);
		wait_kind(3'h2);
		check("ctrl_word", 17'h0_3ABC, {rfl, rw});
		push(1'b1, 1'b1, 16'h0F0F);
		wait_kind(3'h4);
		check("both_valid", 17'h0_0F0F, {1'b0, rw});
		f1 = rfl;
		push(1'b1, 1'b0, 16'hF0F0);
		wait_kind(3'h4);
		check("alt_flag", {16'hF0F0, ~f1}, {rw, rfl});
		$display("test control done");
	endtask : t_ctrl

	task automatic t_slip();
		@(posedge clk);
		rsd <= 1'b1;
		slip <= 1'b1;
		next_word();
		for (int j = 0; j < 3; j++) begin
			next_word();
			check("slip_error", 17'h1, {14'h0, rd, rc, re});
		end
		@(posedge clk);
		rsd <= 1'b0;
		wait_kind(3'h0);
		next_word();
		check("resync_idle", 17'h0, {14'h0, rd, rc, re});
		$display("test slip done");
	endtask : t_slip

	// A range change slips the boundary, so the hunt runs again first
	task automatic t_mode();
		@(posedge clk);
		rng <= 2'h2;
		wait_kind(3'h0);
		wait_kind(3'h0);
		push(1'b1, 1'b0, 16'h5AC3);
		wait_kind(3'h4);
		check("div4_data", 17'h0_5AC3, {1'b0, rw});
		@(posedge clk);
		rsd <= 1'b1;
		esm <= 1'b1;
		fen <= 1'b1;
		fl <= 1'b1;
		repeat (8) next_word();
		push(1'b1, 1'b0, 16'hA5C3);
		wait_kind(3'h4);
		check("esm_data", 17'h1_A5C3, {rfl, rw});
		push(1'b0, 1'b1, 16'h1234);
		wait_kind(3'h2);
		check("esm_ctrl", 17'h0_1234, {rfl, rw});
		$display("test modes done");
	endtask : t_mode

	initial begin
		n_mismatch = 0;
		n_tests = 0;
		{rst_n, dv, cv, fl, lock, rsd, slip, esm} = '0;
		fen = 1'b1;
		din = 16'h0;
		rng = 2'h0;
		repeat (2) @(posedge clk);
		check("ready_in_reset", 17'h0, {16'h0, rdy});
		rst_n <= 1'b1;
		t_idle();
		t_data();
		t_ctrl();
		t_slip();
		t_mode();
		wrap_up();
	end
endmodule : tb_dbc_codec_top

`default_nettype wire
